// ===== design/sfc_map.svh
// Constants of the serial flash command framer: opcodes and frame counts.
// Assumes inclusion by the package and by the framer module.
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

`define SFC_OP_WREN      8'h06
`define SFC_OP_WRDI      8'h04
`define SFC_OP_RDST_LO   8'h05
`define SFC_OP_RDST_HI   8'h35
`define SFC_OP_WRST      8'h01
`define SFC_OP_READ      8'h03
`define SFC_OP_FREAD     8'h0B
`define SFC_OP_PROG      8'h02
`define SFC_OP_SE        8'h20
`define SFC_OP_BE32      8'h52
`define SFC_OP_BE64      8'hD8
`define SFC_OP_CE_A      8'hC7
`define SFC_OP_CE_B      8'h60
`define SFC_OP_DPD       8'hB9
`define SFC_OP_RDPD      8'hAB

// Byte index at which output data begins
`define SFC_OUT_NONE     4'h0
`define SFC_OUT_STATUS   4'h1
`define SFC_OUT_READ     4'h4
`define SFC_OUT_FREAD    4'h5
`define SFC_OUT_ID       4'h4

// Byte counts of write-type frames, byte counter limit and last bit index
`define SFC_LEN_OPC      4'h1
`define SFC_LEN_ADDR     4'h4
`define SFC_LEN_PROG     4'h5
`define SFC_LEN_WRST1    4'h2
`define SFC_LEN_WRST2    4'h3
`define SFC_BYTE_SAT     4'hF
`define SFC_BIT_LAST     3'h7

// Arbitrary neutral identifier value
`define SFC_DEV_ID       8'h5A

`endif

// ===== design/sfc_pkg.sv
// Types of the serial flash command framer.
// Assumes sfc_map.svh is on the include path.
`include "sfc_map.svh"
package sfc_pkg;
  typedef enum logic [3:0] {
    SFC_IDLE = 4'b0001,
    SFC_CAPT = 4'b0010,
    SFC_OUT  = 4'b0100,
    SFC_IGN  = 4'b1000
  } sfc_state_t;
endpackage : sfc_pkg

// ===== design/sfc_framer.sv
// Serial flash command framer: pins sampled by clk, opcode decode, output
// shifting, write enable latch and acceptance of write-type frames.
// Assumes the array/status logic sits on clk and that the host sclk is far
// slower than clk (several clk periods per sclk phase).
// Contract
// - All fields move MSB first, starting at first rising sclk after select.
// - Input bits are sampled on rising sclk, first eight form the opcode.
// - First byte is opcode; it decides address, dummy and data bytes.
// - Read-type opcodes answer with data; host may stop after any bit.
// - Write-type frames run only if clock count is a multiple of eight.
// - Incomplete page program byte: nothing happens, latch stays set; the code still pulses prog_vld for the complete data bytes before it.
// - Opcode ABH leaves deep power-down; with dummies it returns the id.
// - 06H sets the latch; program, erase, status write need it set.
// - 04H, reset and cycle completion clear the latch.
// - 05H returns status low byte, 35H high byte, even while busy.
// - Data reads during an internal cycle are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.svh"

module sfc_framer #(
  parameter logic [7:0] DEV_ID = `SFC_DEV_ID
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe_n,
  // Status and array
  input  wire logic        busy,
  input  wire logic        cycle_done,
  input  wire logic [7:0]  status_lo,
  input  wire logic [7:0]  status_hi,
  input  wire logic [7:0]  mem_rdata,
  output logic [23:0]      mem_addr,
  // Accepted commands
  output logic             cmd_go,
  output logic [7:0]       cmd_op,
  output logic [23:0]      cmd_addr,
  output logic [15:0]      wsr_data,
  output logic             wsr_two,
  output logic             prog_vld,
  output logic [7:0]       prog_byte,
  // Device state
  output logic             write_enable_latch,
  output logic             deep_pd
);
  import sfc_pkg::*;

  function automatic logic [3:0] out_start(input logic [7:0] op);
    case (op)
      `SFC_OP_RDST_LO, `SFC_OP_RDST_HI: out_start = `SFC_OUT_STATUS;
      `SFC_OP_READ:  out_start = `SFC_OUT_READ;
      `SFC_OP_FREAD: out_start = `SFC_OUT_FREAD;
      `SFC_OP_RDPD:  out_start = `SFC_OUT_ID;
      default:       out_start = `SFC_OUT_NONE;
    endcase
  endfunction : out_start

  function automatic logic known(input logic [7:0] op);
    case (op)
      `SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_RDST_LO, `SFC_OP_RDST_HI,
      `SFC_OP_WRST, `SFC_OP_READ, `SFC_OP_FREAD, `SFC_OP_PROG,
      `SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64, `SFC_OP_CE_A,
      `SFC_OP_CE_B, `SFC_OP_DPD, `SFC_OP_RDPD: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction : known

  function automatic logic is_dread(input logic [7:0] op);
    is_dread = (op == `SFC_OP_READ) || (op == `SFC_OP_FREAD);
  endfunction : is_dread

  // Pin synchronisers; stage three only serves edge detection
  logic [2:0] sclk_sy_r;
  logic [2:0] cs_sy_r;
  logic [1:0] si_sy_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sy_r <= 3'h0;
      cs_sy_r   <= 3'h7;
      si_sy_r   <= 2'h0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk};
      cs_sy_r   <= {cs_sy_r[1:0], cs_n};
      si_sy_r   <= {si_sy_r[0], si};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_act;
  assign sclk_rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  assign sclk_fall = ~sclk_sy_r[1] & sclk_sy_r[2];
  assign cs_fall   = ~cs_sy_r[1] & cs_sy_r[2];
  assign cs_rise   = cs_sy_r[1] & ~cs_sy_r[2];
  assign cs_act    = ~cs_sy_r[1];

  // Frame state and counters
  sfc_state_t  state_r;
  logic [2:0]  bit_cnt_r;
  logic [3:0]  byte_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  opcode_r;
  logic [23:0] addr_r;
  logic [15:0] wsr_r;
  logic [7:0]  rx_byte;
  logic [7:0]  op_now;
  logic        byte_done;
  logic [3:0]  byte_inc;

  assign rx_byte   = {shift_r[6:0], si_sy_r[1]};
  assign byte_done = sclk_rise && (bit_cnt_r == `SFC_BIT_LAST);
  assign op_now    = (byte_cnt_r == 4'h0) ? rx_byte : opcode_r;
  assign byte_inc  = (byte_cnt_r == `SFC_BYTE_SAT) ? byte_cnt_r
                     : 4'(byte_cnt_r + 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SFC_IDLE;
    end else if (!cs_act) begin
      state_r <= SFC_IDLE;
    end else begin
      case (state_r)
        SFC_IDLE: begin
          if (cs_fall) begin
            state_r <= SFC_CAPT;
          end
        end
        SFC_CAPT: begin
          if (byte_done && byte_cnt_r == 4'h0 &&
              (!known(rx_byte) ||
               (deep_pd && rx_byte != `SFC_OP_RDPD) ||
               (busy && is_dread(rx_byte)))) begin
            state_r <= SFC_IGN;
          end else if (byte_done && out_start(op_now) == byte_inc) begin
            state_r <= SFC_OUT;
          end
        end
        SFC_OUT: state_r <= SFC_OUT;
        SFC_IGN: state_r <= SFC_IGN;
        default: state_r <= SFC_IDLE;
      endcase
    end
  end

  // Input shifting, MSB first on rising sclk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 4'h0;
      shift_r    <= 8'h00;
    end else if (state_r == SFC_IDLE) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 4'h0;
      shift_r    <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      shift_r   <= rx_byte;
      if (byte_done) begin
        byte_cnt_r <= byte_inc;
      end
    end
  end

  // Field capture: opcode and status write bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_r <= 8'h00;
      wsr_r    <= 16'h0000;
    end else if (state_r == SFC_CAPT && byte_done) begin
      case (byte_cnt_r)
        4'h0: opcode_r <= rx_byte;
        4'h1: wsr_r[7:0] <= rx_byte;
        4'h2: wsr_r[15:8] <= rx_byte;
        default: wsr_r <= wsr_r;
      endcase
    end
  end

  // Output shifting on falling sclk
  logic [7:0] tx_r;
  logic [2:0] tx_cnt_r;
  logic       so_r;
  logic [7:0] tx_next;
  always_comb begin
    case (opcode_r)
      `SFC_OP_RDST_LO: tx_next = status_lo;
      `SFC_OP_RDST_HI: tx_next = status_hi;
      `SFC_OP_RDPD:    tx_next = DEV_ID;
      default:         tx_next = mem_rdata;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r     <= 8'h00;
      tx_cnt_r <= 3'h0;
      so_r     <= 1'b0;
    end else if (state_r != SFC_OUT) begin
      tx_cnt_r <= 3'h0;
    end else if (sclk_fall) begin
      tx_cnt_r <= 3'(tx_cnt_r + 3'h1);
      if (tx_cnt_r == 3'h0) begin
        so_r <= tx_next[7];
        tx_r <= {tx_next[6:0], 1'b0};
      end else begin
        so_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Address: captured, then stepped after each data byte shifted out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 24'h000000;
    end else if (state_r == SFC_CAPT && byte_done) begin
      case (byte_cnt_r)
        4'h1: addr_r[23:16] <= rx_byte;
        4'h2: addr_r[15:8] <= rx_byte;
        4'h3: addr_r[7:0] <= rx_byte;
        default: addr_r <= addr_r;
      endcase
    end else if (state_r == SFC_OUT && sclk_fall &&
                 tx_cnt_r == `SFC_BIT_LAST && is_dread(opcode_r)) begin
      addr_r <= 24'(addr_r + 24'h000001);
    end
  end

  // Page program data strobes; commit waits for cmd_go
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_vld  <= 1'b0;
      prog_byte <= 8'h00;
    end else begin
      prog_vld <= state_r == SFC_CAPT && byte_done &&
                  opcode_r == `SFC_OP_PROG &&
                  byte_cnt_r >= `SFC_LEN_ADDR && !busy;
      if (state_r == SFC_CAPT && byte_done) begin
        prog_byte <= rx_byte;
      end
    end
  end

  // Acceptance at select release
  logic aligned;
  logic wr_ok;
  logic len_ok;
  logic take;
  assign aligned = (bit_cnt_r == 3'h0);
  assign take    = cs_rise && state_r == SFC_CAPT && aligned && !busy &&
                   !deep_pd;
  always_comb begin
    case (opcode_r)
      `SFC_OP_PROG: len_ok = byte_cnt_r >= `SFC_LEN_PROG;
      `SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64:
        len_ok = byte_cnt_r == `SFC_LEN_ADDR;
      `SFC_OP_CE_A, `SFC_OP_CE_B: len_ok = byte_cnt_r == `SFC_LEN_OPC;
      `SFC_OP_WRST: len_ok = byte_cnt_r == `SFC_LEN_WRST1 ||
                             byte_cnt_r == `SFC_LEN_WRST2;
      default: len_ok = 1'b0;
    endcase
  end
  assign wr_ok = take && len_ok && write_enable_latch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_go   <= 1'b0;
      cmd_op   <= 8'h00;
      cmd_addr <= 24'h000000;
      wsr_data <= 16'h0000;
      wsr_two  <= 1'b0;
    end else begin
      cmd_go <= wr_ok;
      if (wr_ok) begin
        cmd_op   <= opcode_r;
        cmd_addr <= addr_r;
        wsr_data <= wsr_r;
        wsr_two  <= byte_cnt_r == `SFC_LEN_WRST2;
      end
    end
  end

  // Write enable latch; a set beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (take && opcode_r == `SFC_OP_WREN &&
                 byte_cnt_r == `SFC_LEN_OPC) begin
      write_enable_latch <= 1'b1;
    end else if ((take && opcode_r == `SFC_OP_WRDI &&
                  byte_cnt_r == `SFC_LEN_OPC) || cycle_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Deep power-down: entered on aligned B9H, left on ABH opcode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_pd <= 1'b0;
    end else if (state_r == SFC_CAPT && byte_done && byte_cnt_r == 4'h0 &&
                 rx_byte == `SFC_OP_RDPD) begin
      deep_pd <= 1'b0;
    end else if (take && opcode_r == `SFC_OP_DPD &&
                 byte_cnt_r == `SFC_LEN_OPC) begin
      deep_pd <= 1'b1;
    end
  end

  assign so       = so_r;
  assign so_oe_n  = (state_r != SFC_OUT);
  assign mem_addr = addr_r;

endmodule : sfc_framer
`default_nettype wire

// ===== testbench/sfc_framer_assertions.sv
// Checker of the framer's pin timing and accept strobes.
// Bound into sfc_framer; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sfc_framer_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe_n,
  // State and strobes
  input wire logic busy,
  input wire logic cycle_done,
  input wire logic cmd_go,
  input wire logic prog_vld,
  input wire logic write_enable_latch,
  input wire logic deep_pd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_go_one_cycle: assert property (cmd_go |=> !cmd_go)
    else $error("accept strobe too long");
  a_go_needs_latch: assert property (cmd_go |-> $past(write_enable_latch))
    else $error("accept without latch");
  a_go_after_select: assert property
    (cmd_go |-> cs_n && $past(cs_n) && $past(cs_n, 2))
    else $error("accept before select rose");
  a_go_when_idle: assert property (cmd_go |-> !$past(busy))
    else $error("accept while busy");
  a_latch_set_sel: assert property ($rose(write_enable_latch) |-> cs_n)
    else $error("latch set inside frame");
  a_latch_clr_cause: assert property
    ($fell(write_enable_latch) |-> $past(cycle_done) || cs_n)
    else $error("latch cleared without cause");
  a_pd_at_select: assert property ($rose(deep_pd) |-> cs_n)
    else $error("power-down inside frame");
  a_oe_start: assert property ($fell(so_oe_n) |-> !cs_n && sclk)
    else $error("output enabled off a rising clock");
  a_oe_off_idle: assert property (cs_n [*5] |-> so_oe_n)
    else $error("output driven while deselected");
  a_so_steady: assert property (sclk [*4] |-> $stable(so))
    else $error("data out moved while clock high");
  a_prog_pulse: assert property (prog_vld |-> !cs_n ##1 !prog_vld)
    else $error("bad program byte strobe");
endmodule : sfc_framer_chk
bind sfc_framer sfc_framer_chk i_sfc_framer_chk (.clk(clk), .rst_n(rst_n),
  .sclk(sclk), .cs_n(cs_n), .so(so), .so_oe_n(so_oe_n), .busy(busy),
  .cycle_done(cycle_done), .cmd_go(cmd_go), .prog_vld(prog_vld),
  .write_enable_latch(write_enable_latch), .deep_pd(deep_pd));
`default_nettype wire

// ===== testbench/sfc_host.sv
// Host serial master model: mode 0 frames, clock idle low.
// Assumes the bench clk; 8 clk per phase gives a 160 ns sclk.
`timescale 1ns/10ps
`default_nettype none
module sfc_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task automatic hp;
    repeat (8) @(posedge clk);
    #1;
  endtask : hp
  // Sends d[n-1:0], returns every bit seen on so at rising sclk
  task automatic xfer(input logic [63:0] d, input int n,
                      output logic [63:0] q);
    q = '0;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      hp();
      sclk = 1'b1;
      q = {q[62:0], so};
      hp();
      sclk = 1'b0;
    end
    hp();
    cs_n = 1'b1;
    si = ~si;
    hp();
  endtask : xfer
endmodule : sfc_host
`default_nettype wire

// ===== testbench/serial_flash_command_framing_tb_top.sv
// Self-checking bench of the command framer with a host model.
// Assumes design/ on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.svh"
module serial_flash_command_framing_tb_top;
  import sfc_pkg::*;
  logic        clk, rst_n, sclk, cs_n, si, so, so_oe_n, busy, cycle_done;
  logic [7:0]  status_lo, status_hi, mem_rdata, cmd_op, prog_byte, b;
  logic [7:0]  exp_p[$];
  logic [23:0] mem_addr, cmd_addr, a;
  logic [15:0] wsr_data;
  logic        cmd_go, wsr_two, prog_vld, latch, deep_pd, oe_seen;
  logic [63:0] q;
  logic [7:0]  exp_q[$];
  logic [7:0]  ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  int          num_errors, checked;
  integer      seed;
  sfc_framer i_sfc_framer (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n), .busy(busy),
    .cycle_done(cycle_done), .status_lo(status_lo), .status_hi(status_hi),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .cmd_go(cmd_go),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .wsr_data(wsr_data),
    .wsr_two(wsr_two), .prog_vld(prog_vld), .prog_byte(prog_byte),
    .write_enable_latch(latch), .deep_pd(deep_pd));
  sfc_host i_sfc_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so));
  // Array content derived from the address, so reads are predictable
  assign mem_rdata = mem_addr[7:0] ^ 8'hC3;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic frame(input logic [63:0] d, input int n);
    oe_seen = 1'b0;
    i_sfc_host.xfer(d, n, q);
    repeat (4) @(posedge clk);
    #1;
  endtask : frame
  task automatic cdone;
    cycle_done = 1'b1;
    @(posedge clk);
    #1 cycle_done = 1'b0;
    @(posedge clk);
    #1;
  endtask : cdone
  // Accept strobes are taken off the queue of expected opcodes
  always @(posedge clk) begin
    if (so_oe_n === 1'b0) oe_seen <= 1'b1;
    if (cmd_go === 1'b1) begin
      if (exp_q.size() == 0) check_val(32'h1, 32'h0);
      else check_val(cmd_op, exp_q.pop_front());
    end
    if (prog_vld === 1'b1) begin
      if (exp_p.size() == 0) check_val(32'h1, 32'h0);
      else check_val(prog_byte, exp_p.pop_front());
    end
  end
  initial begin
    #300000;
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 32'h1ffe;
    {rst_n, busy, cycle_done, oe_seen} = 4'h0;
    {status_lo, status_hi} = 16'h0000;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_val(latch, 1'b0);
    frame(64'h06, 8);
    check_val(latch, 1'b1);
    frame(64'h04, 7);
    check_val(latch, 1'b1);
    frame(64'h04, 8);
    check_val(latch, 1'b0);
    a = 24'($random(seed));
    frame({8'h20, a}, 32);
    for (int k = 0; k < 5; k++) begin
      frame(64'h06, 8);
      exp_q.push_back(ops[k]);
      frame(k < 3 ? {ops[k], a} : ops[k], k < 3 ? 32 : 8);
      if (k < 3) check_val(cmd_addr, a);
      cdone();
      check_val(latch, 1'b0);
    end
    frame(64'h06, 8);
    exp_p.push_back(8'h5A);
    frame({8'h02, a, 8'h5A, 4'h3}, 44);
    check_val(latch, 1'b1);
    b = 8'($random(seed));
    exp_p.push_back(b);
    exp_q.push_back(8'h02);
    frame({8'h02, a, b}, 40);
    check_val(cmd_addr, a);
    cdone();
    frame(64'h06, 8);
    exp_q.push_back(8'h01);
    frame({8'h01, b, ~b}, 24);
    check_val(wsr_data, {~b, b});
    check_val(wsr_two, 1'b1);
    cdone();
    check_val(latch, 1'b0);
    busy = 1'b1;
    status_lo = 8'($random(seed));
    status_hi = 8'($random(seed));
    frame(64'h05 << 16, 24);
    check_val(q[15:0], {2{status_lo}});
    frame(64'h35 << 8, 16);
    check_val(q[7:0], status_hi);
    frame({8'h03, a} << 8, 40);
    check_val(oe_seen, 1'b0);
    busy = 1'b0;
    frame({8'h03, a} << 16, 48);
    check_val(q[15:0], {a[7:0] ^ 8'hC3, (a[7:0] + 8'h01) ^ 8'hC3});
    frame(64'h9F << 16, 24);
    check_val(oe_seen, 1'b0);
    frame(64'hB9, 8);
    check_val(deep_pd, 1'b1);
    frame(64'hAB << 32, 40);
    check_val(q[7:0], `SFC_DEV_ID);
    check_val(deep_pd, 1'b0);
    check_val(exp_q.size(), 0);
    check_val(exp_p.size(), 0);
    give_verdict();
  end
endmodule : serial_flash_command_framing_tb_top
`default_nettype wire
